// [shared/lmsp_pkg.sv]
// Constants and types for the LED matrix scan and PWM core.
// Assumes a 10 MHz system clock and an APB register bus with 32-bit data.
package lmsp_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ   = 10_000_000;
    localparam int SLOT_US  = 128;
    localparam int GAP_US   = 8;
    localparam int SLOT_CYC = SLOT_US * (CLK_HZ / 1_000_000);
    localparam int GAP_CYC  = GAP_US * (CLK_HZ / 1_000_000);

    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int SW_NUM  = 3;
    localparam int CS_NUM  = 4;
    localparam int LED_NUM = SW_NUM * CS_NUM;
    localparam int ADDR_W  = 12;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] CFG_ADDR      = 12'h000;
    localparam logic [ADDR_W-1:0] LEVEL_ADDR    = 12'h004;
    localparam logic [ADDR_W-1:0] STATUS_ADDR   = 12'h008;
    localparam logic [7:0]        PULLDOWN_IDX  = 8'h10;
    localparam logic [7:0]        SOFT_RST_IDX  = 8'h11;
    localparam logic [ADDR_W-1:0] PULLDOWN_ADDR = {2'h0, PULLDOWN_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] SOFT_RST_ADDR = {2'h0, SOFT_RST_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] PWM_BASE      = 12'h080;
    localparam int                CFG_BEN_BIT   = 0;
    localparam int                PWM_LSB       = 0;
    localparam int                MODE_LSB      = 16;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [2:0] PULLDOWN_RST = 3'h0;
    localparam logic [7:0] LEVEL_RST    = 8'h00;
    localparam logic       BEN_RST      = 1'b0;
    localparam logic [9:0] PWM_RST      = 10'h000;
    localparam logic [1:0] MODE_RST     = 2'h0;
    localparam logic [1:0] MODE_PWM     = 2'h0;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        S_SLOT0 = 3'h0,
        S_GAP0  = 3'h1,
        S_SLOT1 = 3'h3,
        S_GAP1  = 3'h2,
        S_SLOT2 = 3'h6,
        S_GAP2  = 3'h7
    } lmsp_scan_e;

    typedef struct packed {
        logic [1:0] auto_breath_mode;
        logic [9:0] pwm;
    } lmsp_led_s;

endpackage

// [verilog/lmsp_scan_pwm_core.sv]
// Scan sequencer, per-dot PWM and APB register file of the LED matrix core.
// Assumes one 10 MHz clock shared with the APB master, async low reset.
//
// Functional notes
// [RULE_01] Pulldown select is bits 2:0, reset 0; 000 none, 001-111 0.5k to 32k.
// [RULE_02] Any read of the soft reset location returns all registers to defaults.
// [RULE_03] Power-up reset loads defaults, so the display starts blank.
// [RULE_04] The three active-low scan switches are enabled one at a time, in order.
// [RULE_05] Each scan slot lasts 128 us, then an 8 us blanking gap.
// [RULE_06] Global current level scales all four current sources as level/256.
// [RULE_07] Each dot has its own PWM data; average current follows the PWM sum.
// [RULE_08] PWM data is a plain binary step count.
// [RULE_09] Each dot selects direct PWM or automatic breathing; no breath engine here, so breathing dots stay dark.
// [RULE_10] Direct PWM when dot mode bits are 00 or breath enable is clear.
// [RULE_11] Host may rewrite PWM values; each new value takes effect.
// [RULE_12] Host should use gamma tables: 32 steps for 1 s, 64 for 2 s.
// [RULE_13] After the third slot and gap the sequencer wraps to the first.
//
// Chosen here: the APB register port.
module lmsp_scan_pwm_core
    import lmsp_pkg::*;
(
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        psel_i,
    input  wire logic                        penable_i,
    input  wire logic                        pwrite_i,
    input  wire logic [lmsp_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                 pwdata_i,
    output logic      [31:0]                 prdata_o,
    output logic                             pready_o,
    output logic                             pslverr_o,
    output logic      [lmsp_pkg::SW_NUM-1:0] scan_switch_n_o,
    output logic      [lmsp_pkg::CS_NUM-1:0] current_source_outputs_o,
    output logic      [7:0]                  global_current_level_o,
    output logic      [2:0]                  pulldown_select_o
);
    import lmsp_pkg::*;

    localparam int CNT_W = 11;
    localparam logic [CNT_W-1:0] SLOT_LAST = CNT_W'(SLOT_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LAST  = CNT_W'(GAP_CYC - 1);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic is_slot(input lmsp_scan_e s);
        is_slot = (s == S_SLOT0) || (s == S_SLOT1) || (s == S_SLOT2);
    endfunction

    function automatic logic [1:0] sw_of(input lmsp_scan_e s);
        case (s)
            S_SLOT0, S_GAP0: sw_of = 2'h0;
            S_SLOT1, S_GAP1: sw_of = 2'h1;
            default:         sw_of = 2'h2;
        endcase
    endfunction

    function automatic logic pwm_hit(input logic [ADDR_W-1:0] a);
        pwm_hit = (a >= PWM_BASE) && (a < PWM_BASE + ADDR_W'(4 * LED_NUM))
                  && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [3:0] pwm_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off     = a - PWM_BASE;
        pwm_idx = off[5:2];
    endfunction

    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    lmsp_scan_e       state;
    logic [CNT_W-1:0] cnt;
    logic             breath_en;
    logic [7:0]       level;
    lmsp_led_s        led [LED_NUM];

    logic xfer;
    logic setup_acc;
    logic soft_rst;
    logic wr;

    assign setup_acc = psel_i && penable_i && !pready_o;
    assign xfer      = psel_i && penable_i && pready_o;
    assign wr        = xfer && pwrite_i;
    assign soft_rst  = xfer && !pwrite_i && (paddr_i == SOFT_RST_ADDR);

    // ----------------------------------------
    // APB handshake, one wait state
    // ----------------------------------------
    logic        next_err;
    logic [31:0] next_rdata;

    always_comb begin
        next_err   = 1'b0;
        next_rdata = 32'h0000_0000;
        case (paddr_i)
            CFG_ADDR:      next_rdata[CFG_BEN_BIT] = breath_en;
            LEVEL_ADDR:    next_rdata[7:0] = level;
            STATUS_ADDR:   next_rdata[2:0] = state;
            PULLDOWN_ADDR: next_rdata[2:0] = pulldown_select_o;
            SOFT_RST_ADDR: next_rdata = 32'h0000_0000;
            default: begin
                if (pwm_hit(paddr_i)) begin
                    next_rdata[PWM_LSB +: 10]  = led[pwm_idx(paddr_i)].pwm;
                    next_rdata[MODE_LSB +: 2]  = led[pwm_idx(paddr_i)].auto_breath_mode;
                end else begin
                    next_err = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= setup_acc;
            prdata_o  <= setup_acc && !pwrite_i ? next_rdata : 32'h0000_0000;
            pslverr_o <= setup_acc && next_err;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            breath_en         <= BEN_RST;      // RULE_03
            level             <= LEVEL_RST;
            pulldown_select_o <= PULLDOWN_RST;
        end else if (soft_rst) begin
            breath_en         <= BEN_RST;      // RULE_02
            level             <= LEVEL_RST;
            pulldown_select_o <= PULLDOWN_RST;
        end else if (wr) begin
            if (paddr_i == CFG_ADDR)
                breath_en <= pwdata_i[CFG_BEN_BIT];
            if (paddr_i == LEVEL_ADDR)
                level <= pwdata_i[7:0];
            if (paddr_i == PULLDOWN_ADDR)
                pulldown_select_o <= pwdata_i[2:0];   // RULE_01
        end
    end

    // ----------------------------------------
    // Per-dot PWM and mode storage
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < LED_NUM; i++) begin
                led[i] <= '{auto_breath_mode: MODE_RST, pwm: PWM_RST};   // RULE_03
            end
        end else if (soft_rst) begin
            for (int i = 0; i < LED_NUM; i++) begin
                led[i] <= '{auto_breath_mode: MODE_RST, pwm: PWM_RST};   // RULE_02
            end
        end else if (wr && pwm_hit(paddr_i)) begin
            led[pwm_idx(paddr_i)].pwm              <= pwdata_i[PWM_LSB +: 10];   // RULE_11
            led[pwm_idx(paddr_i)].auto_breath_mode <= pwdata_i[MODE_LSB +: 2];   // RULE_09
        end
    end

    // ----------------------------------------
    // Scan sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= S_SLOT0;
            cnt   <= '0;
        end else if (is_slot(state) && cnt != SLOT_LAST) begin
            cnt <= cnt + 1'b1;
        end else if (!is_slot(state) && cnt != GAP_LAST) begin
            cnt <= cnt + 1'b1;
        end else begin
            cnt <= '0;
            case (state)
                S_SLOT0: state <= S_GAP0;    // RULE_05
                S_GAP0:  state <= S_SLOT1;
                S_SLOT1: state <= S_GAP1;
                S_GAP1:  state <= S_SLOT2;
                S_SLOT2: state <= S_GAP2;
                S_GAP2:  state <= S_SLOT0;   // RULE_13
                default: state <= S_SLOT0;
            endcase
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    logic [9:0] eff_pwm [CS_NUM];

    always_comb begin
        for (int c = 0; c < CS_NUM; c++) begin
            // Breath engine absent: breathing dots stay dark
            if (led[4 * sw_of(state) + c].auto_breath_mode == MODE_PWM || !breath_en)
                eff_pwm[c] = led[4 * sw_of(state) + c].pwm;   // RULE_10
            else
                eff_pwm[c] = PWM_RST;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scan_switch_n_o          <= '1;
            current_source_outputs_o <= '0;
            global_current_level_o   <= LEVEL_RST;
        end else begin
            for (int s = 0; s < SW_NUM; s++) begin
                scan_switch_n_o[s] <= !(is_slot(state) && sw_of(state) == 2'(s));   // RULE_04
            end
            for (int c = 0; c < CS_NUM; c++) begin
                current_source_outputs_o[c] <= is_slot(state)
                    && (cnt < {1'b0, eff_pwm[c]});   // RULE_07 RULE_08
            end
            global_current_level_o <= level;   // RULE_06
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_wr_pd;
        wr && paddr_i == PULLDOWN_ADDR;
    endsequence

    sequence s_wr_level;
        wr && paddr_i == LEVEL_ADDR;
    endsequence

    property p_pd_write;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        s_wr_pd |=> pulldown_select_o == $past(pwdata_i[2:0]);
    endproperty
    a_pd_write: assert property (p_pd_write) else $error("pulldown write lost");   // RULE_01

    property p_soft_rst;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        soft_rst |=> pulldown_select_o == PULLDOWN_RST && level == LEVEL_RST
                     && !breath_en && led[0].pwm == PWM_RST;
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset incomplete");   // RULE_02

    property p_one_switch;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $onehot0(~scan_switch_n_o);
    endproperty
    a_one_switch: assert property (p_one_switch) else $error("two switches low");   // RULE_04

    property p_slot_len;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $changed(state) && !is_slot(state) |-> $past(cnt) == SLOT_LAST;
    endproperty
    a_slot_len: assert property (p_slot_len) else $error("slot length wrong");   // RULE_05

    property p_gap_len;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $changed(state) && is_slot(state) |-> $past(cnt) == GAP_LAST;
    endproperty
    a_gap_len: assert property (p_gap_len) else $error("gap length wrong");   // RULE_05

    property p_gap_dark;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !is_slot(state) |=> &scan_switch_n_o && current_source_outputs_o == '0;
    endproperty
    a_gap_dark: assert property (p_gap_dark) else $error("output during gap");   // RULE_05

    property p_level;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        s_wr_level |=> ##1 global_current_level_o == $past(pwdata_i[7:0], 2);
    endproperty
    a_level: assert property (p_level) else $error("level not applied");   // RULE_06

    property p_pwm_step;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        state == S_SLOT0 && !breath_en
        |-> ##1 current_source_outputs_o[0] == ($past(cnt) < {1'b0, $past(led[0].pwm)});
    endproperty
    a_pwm_step: assert property (p_pwm_step) else $error("pwm step wrong");   // RULE_08

    property p_breath_dark;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        state == S_SLOT0 && breath_en && led[0].auto_breath_mode != MODE_PWM
        |=> !current_source_outputs_o[0];
    endproperty
    a_breath_dark: assert property (p_breath_dark) else $error("breath dot lit");   // RULE_10

    property p_wrap;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        state == S_GAP2 && cnt == GAP_LAST |=> state == S_SLOT0 ##1 !scan_switch_n_o[0];
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap to first switch");   // RULE_13

    property p_sw1_on;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        state == S_SLOT1 |=> scan_switch_n_o == 3'h5;
    endproperty
    a_sw1_on: assert property (p_sw1_on) else $error("switch 1 off");   // RULE_04

endmodule

// [sim/lmsp_apb_host.sv]
// Host model: the microcontroller side that writes the core's registers over APB.
// Assumes one clock shared with the core; it changes signals only after rising edges.
module lmsp_apb_host
    import lmsp_pkg::*;
(
    input  wire logic                        sys_clk_i,
    input  wire logic                        pready_i,
    input  wire logic                        pslverr_i,
    input  wire logic [31:0]                 prdata_i,
    output logic                             psel_o,
    output logic                             penable_o,
    output logic                             pwrite_o,
    output logic      [lmsp_pkg::ADDR_W-1:0] paddr_o,
    output logic      [31:0]                 pwdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import lmsp_pkg::*;

    initial begin
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        pwrite_o <= 1'b0;
        paddr_o <= '0;
        pwdata_o <= '0;
    end

    // ----------------------------------------
    // One transfer, held until pready
    // ----------------------------------------
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
                        input logic [31:0] data, output logic [31:0] rdata,
                        output logic err);
        @(posedge sys_clk_i);
        psel_o <= 1'b1;
        pwrite_o <= wr;
        paddr_o <= addr;
        pwdata_o <= data;
        @(posedge sys_clk_i);
        penable_o <= 1'b1;
        @(posedge sys_clk_i);
        while (pready_i !== 1'b1) begin
            @(posedge sys_clk_i);
        end
        rdata = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        paddr_o <= ~addr;
        pwdata_o <= ~data;
    endtask
endmodule

// [sim/lmsp_scan_pwm_core_tb_top.sv]
// Self-checking bench of the LED matrix scan and PWM core.
// Assumes the APB host model lmsp_apb_host and the lmsp_pkg package.
module lmsp_scan_pwm_core_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import lmsp_pkg::*;

    logic              sys_clk;
    logic              rst_n;
    logic              psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd_v;
    logic              rd_e;
    logic [SW_NUM-1:0] scan_n;
    logic [CS_NUM-1:0] cs_out;
    logic [7:0]        level;
    logic [2:0]        pd;
    int                failures = 0;
    int                checks = 0;
    int                cycles = 0;

    lmsp_scan_pwm_core u_lmsp_scan_pwm_core (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .scan_switch_n_o(scan_n), .current_source_outputs_o(cs_out),
        .global_current_level_o(level), .pulldown_select_o(pd));

    lmsp_apb_host u_lmsp_apb_host (.sys_clk_i(sys_clk), .pready_i(pready),
        .pslverr_i(pslverr), .prdata_i(prdata), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        u_lmsp_apb_host.xfer(1'b1, a, d, rd_v, rd_e);
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic err);
        u_lmsp_apb_host.xfer(1'b0, a, 32'h0000_0000, rd_v, rd_e);
        chk("read data", exp, rd_v);
        chk("pslverr", {31'h0, err}, {31'h0, rd_e});
        repeat (2) @(negedge sys_clk);
    endtask

    // Lit cycles of one source over one slot and its gap
    task automatic count_lit(input int sw, input int src, output int n);
        n = 0;
        while (scan_n[sw] !== 1'b1) @(negedge sys_clk);
        while (scan_n[sw] !== 1'b0) @(negedge sys_clk);
        repeat (SLOT_CYC + GAP_CYC) begin
            if (cs_out[src] === 1'b1) n++;
            @(negedge sys_clk);
        end
    endtask

    task automatic report_and_stop();
        if (failures == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_scan();
        logic [2:0] seq [6] = '{3'b110, 3'b111, 3'b101, 3'b111, 3'b011, 3'b111};
        int n;
        while (scan_n !== 3'b011) @(negedge sys_clk);
        while (scan_n !== 3'b110) @(negedge sys_clk);
        for (int p = 0; p < 7; p++) begin
            n = 0;
            while (scan_n === seq[p % 6]) begin
                n++;
                @(negedge sys_clk);
            end
            chk("scan phase length", (p % 2) ? GAP_CYC : SLOT_CYC, n);
        end
        rd(STATUS_ADDR, {29'h0, S_GAP0}, 1'b0);
    endtask

    task automatic t_regs();
        for (int c = 0; c < 8; c++) begin
            wr(PULLDOWN_ADDR, 32'hFFFF_FFF8 | c);
            chk("pulldown out", c, {29'h0, pd});
            rd(PULLDOWN_ADDR, c, 1'b0);
        end
        wr(LEVEL_ADDR, 32'h0000_01A5);
        chk("level out", 32'h0000_00A5, {24'h0, level});
        rd(LEVEL_ADDR, 32'h0000_00A5, 1'b0);
        rd(12'hFFC, 32'h0000_0000, 1'b1);
    endtask

    task automatic t_pwm();
        int vals [4] = '{0, 4, 255, 1023};
        int n;
        foreach (vals[i]) begin
            wr(PWM_BASE, vals[i]);
            count_lit(0, 0, n);
            chk("dot0 lit cycles", vals[i], n);
        end
        wr(PWM_BASE + 12'h014, 32'h0001_0007);
        count_lit(1, 1, n);
        chk("breath off lit", 7, n);
        wr(CFG_ADDR, 32'h0000_0001);
        for (int m = 0; m < 4; m++) begin
            wr(PWM_BASE + 12'h014, (m << MODE_LSB) | 7);
            count_lit(1, 1, n);
            chk("mode lit cycles", (m == 0) ? 7 : 0, n);
        end
        wr(PWM_BASE, 32'h0001_0005);
        count_lit(0, 0, n);
        chk("breath dot0 lit", 0, n);
    endtask

    task automatic t_soft_reset();
        int n;
        wr(PULLDOWN_ADDR, 32'h0000_0005);
        wr(LEVEL_ADDR, 32'h0000_0033);
        wr(PWM_BASE, 32'h0000_0009);
        wr(SOFT_RST_ADDR, 32'hFFFF_FFFF);
        chk("pulldown kept", 5, {29'h0, pd});
        rd(SOFT_RST_ADDR, 32'h0000_0000, 1'b0);
        chk("pulldown after", 0, {29'h0, pd});
        chk("level after", 0, {24'h0, level});
        rd(CFG_ADDR, 32'h0000_0000, 1'b0);
        rd(PWM_BASE, 32'h0000_0000, 1'b0);
        count_lit(0, 0, n);
        chk("dot0 after", 0, n);
    endtask

    // ----------------------------------------
    // Clock, reset, sequence, timeout
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 100000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("reset outputs", 32'h0003_8000, {14'h0, scan_n, cs_out, level, pd});
        @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(PULLDOWN_ADDR, 32'h0000_0000, 1'b0);
        rd(LEVEL_ADDR, 32'h0000_0000, 1'b0);
        t_scan();
        t_regs();
        t_pwm();
        t_soft_reset();
        report_and_stop();
    end
endmodule
